// [hw/wds_regs.vh]
// Constants for the watchdog supervisor
// ****************************************************************
// ****************************************************************
`ifndef WDS_REGS_VH
`define WDS_REGS_VH

`define WDS_CNT_W 26
`define WDS_WIN_CLKS 26'h0000200
`define WDS_TO_SEL0 26'h0010000
`define WDS_TO_SEL1 26'h0080000
`define WDS_TO_SEL2 26'h0400000
`define WDS_TO_SEL3 26'h2000000
`define WDS_XIC_RESTART 0
`define WDS_XIC_RUN 1
`define WDS_XIC_FLAG 3
`define WDS_WDC_RSTFLAG 2
`define WDS_XIE_IEN 4
`define WDS_CKC_SEL_HI 7
`define WDS_CKC_SEL_LO 6
`define WDS_RST_PULSE_CLKS 4'h4

`endif

// [hw/wds_pulse.v]
// Stretches the watchdog reset request into a fixed-length pulse
`timescale 1ns/1ps
`include "wds_regs.vh"

module wds_pulse (
    input wire clk,
    input wire rst,
    input wire trig,
    output reg pulse_r
);
    reg [3:0] cnt_r;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 4'h0;
            pulse_r <= 1'b0;
        end else if (trig) begin
            cnt_r <= `WDS_RST_PULSE_CLKS;
            pulse_r <= 1'b1;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
            pulse_r <= (cnt_r != 4'h1);
        end else begin
            pulse_r <= 1'b0;
        end
    end
endmodule // wds_pulse

// [hw/wds_watchdog.v]
// Watchdog supervisor: counter, timeout flag, reset window and control bits
`timescale 1ns/1ps
`include "wds_regs.vh"

module wds_watchdog (
    input wire clk,
    input wire rst,
    input wire [7:0] xic_wdata,
    input wire xic_we,
    input wire [7:0] wdc_wdata,
    input wire wdc_we,
    input wire [7:0] ckc_wdata,
    input wire ckc_we,
    input wire [7:0] xie_wdata,
    input wire xie_we,
    input wire isr_exit,
    output reg timeout_interrupt_flag,
    output reg watchdog_run_enable,
    output reg watchdog_reset_flag,
    output reg timeout_select_high,
    output reg timeout_select_low,
    output reg timeout_interrupt_enable,
    output wire wd_irq,
    output wire cpu_reset,
    output reg [25:0] count_r
);
    // ****************************************************************
    // Internal state
    // ****************************************************************
    reg in_window_r;
    reg [9:0] win_cnt_r;
    reg irq_pend_r;
    reg [25:0] limit;
    wire restart_wr;
    wire rstflag_zero_wr;
    wire to_hit;
    wire win_end;
    wire wd_reset;

    always @* begin
        case ({timeout_select_high, timeout_select_low})
            2'b00: limit = `WDS_TO_SEL0;
            2'b01: limit = `WDS_TO_SEL1;
            2'b10: limit = `WDS_TO_SEL2;
            2'b11: limit = `WDS_TO_SEL3;
            default: limit = `WDS_TO_SEL0;
        endcase
    end

    // Restart only counts while the timeout flag is set, before the reset flag sets
    assign restart_wr = xic_we && xic_wdata[`WDS_XIC_RESTART]
        && timeout_interrupt_flag && !watchdog_reset_flag;
    assign rstflag_zero_wr = wdc_we && !wdc_wdata[`WDS_WDC_RSTFLAG];
    assign to_hit = watchdog_run_enable && !in_window_r
        && (count_r == limit - 26'h1);
    assign win_end = watchdog_run_enable && in_window_r
        && (win_cnt_r == 10'h1ff) && !restart_wr;
    assign wd_reset = win_end;

    // ****************************************************************
    // Counter and window
    // ****************************************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            count_r <= 26'h0;
            in_window_r <= 1'b0;
            win_cnt_r <= 10'h0;
        end else if (restart_wr || wd_reset
                || (rstflag_zero_wr && watchdog_reset_flag)) begin
            count_r <= 26'h0;
            in_window_r <= 1'b0;
            win_cnt_r <= 10'h0;
        end else if (watchdog_run_enable) begin
            if (to_hit) begin
                count_r <= 26'h0;
                in_window_r <= 1'b1;
                win_cnt_r <= 10'h0;
            end else if (in_window_r) begin
                win_cnt_r <= win_cnt_r + 10'h1;
            end else begin
                count_r <= count_r + 26'h1;
            end
        end
    end

    // ****************************************************************
    // Control and status bits
    // ****************************************************************
    // External pin reset (rst) clears enables and flags; set beats clear on the flags, but a wd_reset clear beats an xie enable write
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            timeout_interrupt_flag <= 1'b0;
            watchdog_run_enable <= 1'b0;
            watchdog_reset_flag <= 1'b0;
            timeout_select_high <= 1'b0;
            timeout_select_low <= 1'b0;
            timeout_interrupt_enable <= 1'b0;
            irq_pend_r <= 1'b0;
        end else begin
            if (xic_we)
                watchdog_run_enable <= xic_wdata[`WDS_XIC_RUN];
            if (ckc_we) begin
                timeout_select_high <= ckc_wdata[`WDS_CKC_SEL_HI];
                timeout_select_low <= ckc_wdata[`WDS_CKC_SEL_LO];
            end
            if (wd_reset) begin
                timeout_interrupt_flag <= 1'b0;
                timeout_interrupt_enable <= 1'b0;
                watchdog_reset_flag <= 1'b1;
            end else begin
                if (xie_we)
                    timeout_interrupt_enable <= xie_wdata[`WDS_XIE_IEN];
                if (to_hit)
                    timeout_interrupt_flag <= 1'b1;
                else if (xic_we && !xic_wdata[`WDS_XIC_FLAG])
                    timeout_interrupt_flag <= 1'b0;
                else if (restart_wr)
                    timeout_interrupt_flag <= 1'b0;
                if (rstflag_zero_wr)
                    watchdog_reset_flag <= 1'b0;
            end
            // Pending request re-arms when the service routine exits
            if (to_hit)
                irq_pend_r <= 1'b1;
            else if (isr_exit && timeout_interrupt_flag)
                irq_pend_r <= 1'b1;
            else if (!timeout_interrupt_flag)
                irq_pend_r <= 1'b0;
        end
    end

    assign wd_irq = irq_pend_r && timeout_interrupt_flag
        && timeout_interrupt_enable;

    wds_pulse u_pulse (
        .clk(clk),
        .rst(rst),
        .trig(wd_reset),
        .pulse_r(cpu_reset)
    );
endmodule // wds_watchdog

// [tb/wds_wd_props.sv]
// Concurrent checks on the watchdog supervisor ports
`timescale 1ns/1ps
module wds_wd_props (
    input clk, rst, xic_we, wdc_we, ckc_we,
    input [7:0] xic_wdata, wdc_wdata, ckc_wdata,
    input timeout_interrupt_flag, watchdog_run_enable, watchdog_reset_flag,
    input timeout_select_high, timeout_select_low, timeout_interrupt_enable,
    input wd_irq, cpu_reset,
    input [25:0] count_r
);
    wire fl = timeout_interrupt_flag;
    wire rf = watchdog_reset_flag;
    wire en = watchdog_run_enable;
    wire ie = timeout_interrupt_enable;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    flag_set_a: assert property (
        en && !timeout_select_high && !timeout_select_low && !wdc_we
        && count_r == 26'hffff |=> fl) else $error("flag missed");
    irq_gate_a: assert property (
        wd_irq |-> ie && fl) else $error("irq without cause");
    pin_rst_a: assert property (
        $fell(rst) |-> !fl && !en && !ie) else $error("pin reset");
    wd_rst_a: assert property (
        $rose(rf) |-> !fl && !ie ##[0:1] cpu_reset) else $error("wd reset");
    restart_a: assert property (
        xic_we && xic_wdata[0] && fl && !rf |=> count_r == 26'h0 && !fl)
        else $error("restart ignored");
    hold_a: assert property (
        !en && !xic_we && !wdc_we |=> $stable(count_r))
        else $error("count moved");
    rf_clr_a: assert property (
        wdc_we && !wdc_wdata[2] |=> !rf && (!$past(rf) || count_r == 26'h0))
        else $error("reset flag clear");
    sel_a: assert property (
        ckc_we |=> {timeout_select_high, timeout_select_low}
        == $past(ckc_wdata[7:6])) else $error("select");
    cover property (fl && wd_irq);
    cover property ($rose(rf));
    cover property (xic_we && xic_wdata[0] && fl);
endmodule // wds_wd_props
bind wds_watchdog wds_wd_props u_props (.*);

// [tb/tb.sv]
// Self-checking bench for the watchdog supervisor
`timescale 1ns/1ps
module tb;
    reg clk, rst, xic_we, wdc_we, ckc_we, xie_we, isr_exit;
    reg [7:0] xic_wdata, wdc_wdata, ckc_wdata, xie_wdata;
    wire fl, run, rf, sh, sl, ie, irq, cr;
    wire [25:0] cnt;
    integer errors = 0, n_tests = 0, n;
    reg [25:0] c0;
    wds_watchdog uut (.clk(clk), .rst(rst), .xic_wdata(xic_wdata),
        .xic_we(xic_we), .wdc_wdata(wdc_wdata), .wdc_we(wdc_we),
        .ckc_wdata(ckc_wdata), .ckc_we(ckc_we),
        .xie_wdata(xie_wdata), .xie_we(xie_we), .isr_exit(isr_exit),
        .timeout_interrupt_flag(fl), .watchdog_run_enable(run),
        .watchdog_reset_flag(rf), .timeout_select_high(sh),
        .timeout_select_low(sl), .timeout_interrupt_enable(ie),
        .wd_irq(irq), .cpu_reset(cr), .count_r(cnt));
    task finish_test;
        begin
            if (errors == 0 && n_tests > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task chk(input [25:0] got, input [25:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task tick(input integer k);
        begin
            repeat (k) @(posedge clk);
            #1;
        end
    endtask
    // One-cycle write strobe; r picks xic, wdc, ckc, xie
    task wr(input [1:0] r, input [7:0] d);
        begin
            {xic_wdata, wdc_wdata, ckc_wdata, xie_wdata} = {4{d}};
            {xic_we, wdc_we, ckc_we, xie_we} = 4'h8 >> r;
            tick(1);
            {xic_we, wdc_we, ckc_we, xie_we} = 4'h0;
        end
    endtask
    // Bounded wait on the timeout flag (s=0) or reset flag (s=1)
    task waitf(input s);
        begin
            n = 0;
            while ((s ? rf : fl) !== 1'b1 && n < 70000) begin
                tick(1);
                n = n + 1;
            end
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #600000;
        errors = errors + 1;
        finish_test;
    end
    initial begin
        rst = 1'b1;
        {xic_we, wdc_we, ckc_we, xie_we, isr_exit} = 5'h0;
        {xic_wdata, wdc_wdata, ckc_wdata, xie_wdata} = 32'h0;
        tick(4);
        rst = 1'b0;
        chk({fl, run, rf, ie, cr}, 5'h0);
        wr(2, 8'hc0);
        chk({sh, sl}, 2'h3);
        wr(2, 8'h00);
        wr(3, 8'h10);
        wr(0, 8'h02);
        tick(20);
        wr(0, 8'h03);
        tick(2);
        chk(cnt < 26'h10, 1'b0);
        wr(0, 8'h00);
        c0 = cnt;
        tick(10);
        chk(cnt, c0);
        wr(0, 8'h02);
        waitf(0);
        chk(n + c0 > 65528 && n + c0 < 65540, 1'b1);
        chk(irq, 1'b1);
        isr_exit = 1'b1;
        tick(1);
        isr_exit = 1'b0;
        tick(1);
        chk(irq, 1'b1);
        wr(0, 8'h03);
        chk({fl, cnt < 26'h4}, 2'h1);
        waitf(0);
        waitf(1);
        chk(n > 507 && n < 516, 1'b1);
        chk({fl, ie}, 2'h0);
        tick(1);
        chk(cr, 1'b1);
        wr(0, 8'h03);
        chk(rf, 1'b1);
        wr(1, 8'h00);
        chk({rf, cnt < 26'h4}, 2'h1);
        rst = 1'b1;
        tick(1);
        rst = 1'b0;
        chk(run, 1'b0);
        finish_test;
    end
endmodule // tb
